/* File: core/led_ctrl_defs.vh */
`ifndef LED_CTRL_DEFS_VH
`define LED_CTRL_DEFS_VH
// register addresses
`define ADDR_LED_FUNCTION_CONFIG 8'h01
`define ADDR_PUMP_MODE_CONFIG    8'h02
`define ADDR_TORCH_LEVEL         8'h05
`define ADDR_SENSE_THRESHOLD     8'h06
`define ADDR_THERM_REFERENCE     8'h09
// led_function_config fields
`define LFC_LED1          0
`define LFC_LED2          1
`define LFC_LAMP_FORCE    3
`define LFC_BIAS_EN       4
`define LFC_FEEDBACK_EN   5
`define LFC_THERM_EN      6
// pump_mode_config fields
`define PMC_INDICATOR     0
`define PMC_PRECHARGE     1
`define PMC_PUMP_EN       2
`define PMC_I2C_TRIG      4
`define PMC_FLASH_SEL     5
`define PMC_PUMP_IN_FLASH 6
// thermistor reference latch clear bit
`define TREF_CLEAR        7
// thresholds
`define TORCH_TIMEOUT_LEVEL 8'h3f
`define LAMP_AUTO_LEVEL     8'h3f
`define LAMP_TIMEOUT_MS     200
`define CLK_MHZ             100
`define TIMEOUT_W           25
`endif

/* File: core/led_mode_protection_control.v */
`timescale 1ns/1ps
`include "led_ctrl_defs.vh"
// How it works
// - bits 0/1 select LED channels
// - mode bit 5 low selects torch
// - bit 6 keeps pump during flash
// - bit 2 enables charge pump
// - bit 1 enables precharge
// - indicator mode disables flash timeout
// - indicator drives first LED only
// - indicator suspends torch, later restores
// - indicator turns gates off, mirror only
// - indicator overrides flash and torch
// - light feedback truncates flash pulse
// - one truncation per flash, trigger rearms
// - bias output when pump or enable
// - lamp timeout when torch above limit
// - force bit starts lamp timeout
// - lamp never during power flash
// - thermistor fault stops pump, flash and torch
// - fault clears on pulse when cool
// - torch uses level, timeout above limit
module led_mode_protection_control #(
	parameter LAMP_TIMEOUT_CYCLES = `LAMP_TIMEOUT_MS * 1000 * `CLK_MHZ
) (
	// clock and reset
	input  wire       clk_sys,
	input  wire       rst,
	// register write port
	input  wire       reg_wr,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	// register read port
	output reg  [7:0] reg_rdata,
	// flash control
	input  wire       flash_trigger_pin,
	input  wire       flash_done,
	// analog comparators
	input  wire       light_above_threshold,
	input  wire       thermistor_below_ref,
	// outputs
	output reg        pump_run,
	output reg        precharge_on,
	output reg        sensor_bias_output,
	output reg  [1:0] gate_drive,
	output reg  [1:0] torch_mirror_on,
	output reg        indicator_mirror_on,
	output reg        torch_active,
	output reg        lamp_timeout_active,
	output reg        flash_timeout_active,
	output reg        thermal_fault
);
	reg [7:0] led_function_config_reg;
	reg [7:0] pump_mode_config_reg;
	reg [7:0] torch_level_reg;
	reg [7:0] sense_threshold_reg;
	reg [7:0] therm_reference_reg;
	reg       flash_active_reg;
	reg       trunc_latch_reg;
	reg       trig_pin_reg;
	reg       i2c_trig_reg;
	reg [`TIMEOUT_W-1:0] lamp_cnt_reg;
	reg       lamp_expired_reg;
	reg       clear_seen_reg;

	wire [1:0] led_sel     = led_function_config_reg[1:0];
	wire       indicator   = pump_mode_config_reg[`PMC_INDICATOR];
	wire       flash_sel   = pump_mode_config_reg[`PMC_FLASH_SEL];
	wire       pump_en     = pump_mode_config_reg[`PMC_PUMP_EN];
	wire       feedback_en = led_function_config_reg[`LFC_FEEDBACK_EN];
	wire       therm_en    = led_function_config_reg[`LFC_THERM_EN];
	wire       trig_i2c    = pump_mode_config_reg[`PMC_I2C_TRIG];
	// new flash triggers from pin or register edge
	wire trig_event = (flash_trigger_pin & ~trig_pin_reg) | (trig_i2c & ~i2c_trig_reg);
	wire trunc_now  = feedback_en & light_above_threshold & flash_active_reg & ~trunc_latch_reg;
	wire fault_now  = therm_en & thermistor_below_ref;
	wire clr_bit    = therm_reference_reg[`TREF_CLEAR];
	// torch: selected mode, not in indicator, no fault
	wire torch_on   = ~flash_sel & ~indicator & ~thermal_fault;
	wire lamp_need  = torch_on & ((torch_level_reg > `LAMP_AUTO_LEVEL) |
		led_function_config_reg[`LFC_LAMP_FORCE]);

	// led function configuration register
	always @(posedge clk_sys) begin
		if (rst) begin
			led_function_config_reg <= 8'h00;
		end else if (reg_wr && reg_addr == `ADDR_LED_FUNCTION_CONFIG) begin
			led_function_config_reg <= reg_wdata;
		end
	end

	// torch level register, also sets the picture light level
	always @(posedge clk_sys) begin
		if (rst) begin
			torch_level_reg <= 8'h00;
		end else if (reg_wr && reg_addr == `ADDR_TORCH_LEVEL) begin
			torch_level_reg <= reg_wdata;
		end
	end

	// sense threshold register, stored for the analog comparator
	always @(posedge clk_sys) begin
		if (rst) begin
			sense_threshold_reg <= 8'h00;
		end else if (reg_wr && reg_addr == `ADDR_SENSE_THRESHOLD) begin
			sense_threshold_reg <= reg_wdata;
		end
	end

	// thermistor reference register with latch clear bit
	always @(posedge clk_sys) begin
		if (rst) begin
			therm_reference_reg <= 8'h00;
		end else if (reg_wr && reg_addr == `ADDR_THERM_REFERENCE) begin
			therm_reference_reg <= reg_wdata;
		end
	end

	// pump and mode register, i2c trigger self clears at flash done or truncation
	always @(posedge clk_sys) begin
		if (rst) begin
			pump_mode_config_reg <= 8'h00;
		end else if (reg_wr && reg_addr == `ADDR_PUMP_MODE_CONFIG) begin
			pump_mode_config_reg <= reg_wdata;
		end else if (flash_active_reg && (flash_done || trunc_now)) begin
			pump_mode_config_reg[`PMC_I2C_TRIG] <= 1'b0; // host write wins
		end
	end

	// register read mux
	always @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else begin
			case (reg_addr)
				`ADDR_LED_FUNCTION_CONFIG: reg_rdata <= led_function_config_reg;
				`ADDR_PUMP_MODE_CONFIG:    reg_rdata <= pump_mode_config_reg;
				`ADDR_TORCH_LEVEL:         reg_rdata <= torch_level_reg;
				`ADDR_SENSE_THRESHOLD:     reg_rdata <= sense_threshold_reg;
				`ADDR_THERM_REFERENCE:     reg_rdata <= therm_reference_reg;
				default:                   reg_rdata <= {6'h00, trunc_latch_reg, thermal_fault};
			endcase
		end
	end

	// previous trigger levels for edge detection
	always @(posedge clk_sys) begin
		if (rst) begin
			trig_pin_reg <= 1'b0;
			i2c_trig_reg <= 1'b0;
		end else begin
			trig_pin_reg <= flash_trigger_pin;
			i2c_trig_reg <= trig_i2c;
		end
	end

	// flash state next values, a new trigger rearms the latch
	reg flash_active_next;
	reg trunc_latch_next;
	always @* begin
		flash_active_next = flash_active_reg;
		trunc_latch_next  = trunc_latch_reg;
		if (trig_event && flash_sel && !indicator && !thermal_fault) begin
			flash_active_next = 1'b1;
			trunc_latch_next  = 1'b0;
		end else if (trunc_now) begin
			flash_active_next = 1'b0;
			trunc_latch_next  = 1'b1;
		end else if (flash_done || thermal_fault || !flash_sel) begin
			flash_active_next = 1'b0;
		end
	end

	// flash state registers
	always @(posedge clk_sys) begin
		if (rst) begin
			flash_active_reg <= 1'b0;
			trunc_latch_reg  <= 1'b0;
		end else begin
			flash_active_reg <= flash_active_next;
			trunc_latch_reg  <= trunc_latch_next;
		end
	end

	// previous latch clear bit, for its falling edge
	always @(posedge clk_sys) begin
		if (rst) begin
			clear_seen_reg <= 1'b0;
		end else begin
			clear_seen_reg <= clr_bit;
		end
	end

	// thermistor fault latch, set wins over clear
	always @(posedge clk_sys) begin
		if (rst) begin
			thermal_fault <= 1'b0;
		end else if (fault_now) begin
			thermal_fault <= 1'b1;
		end else if (clear_seen_reg && !clr_bit) begin
			thermal_fault <= 1'b0;
		end
	end

	// picture light counter next values
	reg [`TIMEOUT_W-1:0] lamp_cnt_next;
	reg                  lamp_expired_next;
	always @* begin
		lamp_cnt_next     = lamp_cnt_reg;
		lamp_expired_next = lamp_expired_reg;
		if (!lamp_need || flash_active_reg) begin
			lamp_cnt_next     = {`TIMEOUT_W{1'b0}};
			lamp_expired_next = 1'b0;
		end else if (lamp_cnt_reg == LAMP_TIMEOUT_CYCLES[`TIMEOUT_W-1:0] - 1'b1) begin
			lamp_expired_next = 1'b1;
		end else begin
			lamp_cnt_next = lamp_cnt_reg + 1'b1;
		end
	end

	// picture light counter registers
	always @(posedge clk_sys) begin
		if (rst) begin
			lamp_cnt_reg     <= {`TIMEOUT_W{1'b0}};
			lamp_expired_reg <= 1'b0;
		end else begin
			lamp_cnt_reg     <= lamp_cnt_next;
			lamp_expired_reg <= lamp_expired_next;
		end
	end

	// gate drive next value, flash only, off in indicator
	reg [1:0] gate_drive_next;
	always @* begin
		gate_drive_next = 2'b00;
		if (flash_active_reg && !indicator && !thermal_fault) begin
			gate_drive_next = led_sel;
		end
	end

	// torch mirror next value, never with a power flash
	reg [1:0] torch_mirror_next;
	always @* begin
		torch_mirror_next = 2'b00;
		if (torch_on && !lamp_expired_reg && !flash_active_reg) begin
			torch_mirror_next = led_sel;
		end
	end

	// indicator mirror next value, first channel only
	reg indicator_mirror_next;
	always @* begin
		indicator_mirror_next = 1'b0;
		if (indicator) begin
			indicator_mirror_next = led_sel[`LFC_LED1];
		end
	end

	// charge pump run, stopped by fault, or by flash when bit 6 is clear
	always @(posedge clk_sys) begin
		if (rst) begin
			pump_run <= 1'b0;
		end else begin
			pump_run <= pump_en & ~thermal_fault & ~fault_now &
				~(flash_active_reg & ~pump_mode_config_reg[`PMC_PUMP_IN_FLASH]);
		end
	end

	// precharge control
	always @(posedge clk_sys) begin
		if (rst) begin
			precharge_on <= 1'b0;
		end else begin
			precharge_on <= pump_mode_config_reg[`PMC_PRECHARGE];
		end
	end

	// sensor bias, follows the registered pump state
	always @(posedge clk_sys) begin
		if (rst) begin
			sensor_bias_output <= 1'b0;
		end else begin
			sensor_bias_output <= pump_run | led_function_config_reg[`LFC_BIAS_EN];
		end
	end

	// external gate drives
	always @(posedge clk_sys) begin
		if (rst) begin
			gate_drive <= 2'b00;
		end else begin
			gate_drive <= gate_drive_next;
		end
	end

	// torch and picture light mirrors
	always @(posedge clk_sys) begin
		if (rst) begin
			torch_mirror_on <= 2'b00;
		end else begin
			torch_mirror_on <= torch_mirror_next;
		end
	end

	// indicator mirror
	always @(posedge clk_sys) begin
		if (rst) begin
			indicator_mirror_on <= 1'b0;
		end else begin
			indicator_mirror_on <= indicator_mirror_next;
		end
	end

	// torch mode status
	always @(posedge clk_sys) begin
		if (rst) begin
			torch_active <= 1'b0;
		end else begin
			torch_active <= torch_on;
		end
	end

	// picture light timeout status
	always @(posedge clk_sys) begin
		if (rst) begin
			lamp_timeout_active <= 1'b0;
		end else begin
			lamp_timeout_active <= lamp_need & ~flash_active_reg;
		end
	end

	// flash timeout status, off in indicator mode
	always @(posedge clk_sys) begin
		if (rst) begin
			flash_timeout_active <= 1'b0;
		end else begin
			flash_timeout_active <= flash_active_reg & ~indicator;
		end
	end
endmodule

/* File: test/led_ctrl_properties.sv */
`timescale 1ns/1ps
module led_ctrl_checker (
	// clock and reset
	input wire       clk_sys,
	input wire       rst,
	// register writes
	input wire       reg_wr,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	// outputs
	input wire       pump_run,
	input wire       precharge_on,
	input wire       sensor_bias_output,
	input wire [1:0] gate_drive,
	input wire [1:0] torch_mirror_on,
	input wire       indicator_mirror_on,
	input wire       torch_active,
	input wire       lamp_timeout_active,
	input wire       thermal_fault
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// write of the latch clear bit going low
	wire clr_wr = reg_wr && reg_addr == 8'h09 && !reg_wdata[7];
	// a single-cycle write, not repeated in the next cycle
	sequence wr_hold(a);
		reg_wr && reg_addr == a ##1 !(reg_wr && reg_addr == a);
	endsequence
	AST_PRECHARGE: assert property (wr_hold(8'h02) |=> precharge_on == $past(reg_wdata[1], 2))
		else $error("precharge bad");
	AST_PUMP_OFF: assert property (wr_hold(8'h02) ##0 !$past(reg_wdata[2]) |=> !pump_run)
		else $error("pump not off");
	AST_FLASH_SEL: assert property (wr_hold(8'h02) ##0 $past(reg_wdata[5]) |=> !torch_active)
		else $error("torch in flash mode");
	AST_LED1_OFF: assert property (wr_hold(8'h01) ##0 !$past(reg_wdata[0]) |=>
		!torch_mirror_on[0] && !gate_drive[0] && !indicator_mirror_on) else $error("led1 driven");
	AST_FAULT_OFF: assert property (thermal_fault |=> !pump_run && gate_drive == 2'b00 && torch_mirror_on == 2'b00)
		else $error("fault not stopping");
	AST_FAULT_HOLD: assert property ($fell(thermal_fault) |-> $past(clr_wr) || $past(clr_wr, 2))
		else $error("fault cleared alone");
	AST_BIAS: assert property (pump_run |=> sensor_bias_output)
		else $error("bias off");
	AST_NO_LAMP_FLASH: assert property (!(lamp_timeout_active && gate_drive != 2'b00))
		else $error("lamp with flash");
endmodule
bind led_mode_protection_control led_ctrl_checker led_ctrl_checker_i (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .pump_run(pump_run), .precharge_on(precharge_on),
	.sensor_bias_output(sensor_bias_output), .gate_drive(gate_drive), .torch_mirror_on(torch_mirror_on),
	.indicator_mirror_on(indicator_mirror_on), .torch_active(torch_active),
	.lamp_timeout_active(lamp_timeout_active), .thermal_fault(thermal_fault));

/* File: test/host_model.sv */
`timescale 1ns/1ps
module host_model (
	// clock
	input wire       clk_sys,
	// register write port
	output reg       reg_wr,
	output reg [7:0] reg_addr,
	output reg [7:0] reg_wdata
);
	// idle bus
	initial begin
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// one write held through its sampling edge, data scrambled after
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge clk_sys);
			reg_wr <= 1'b1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge clk_sys);
			reg_wr <= 1'b0;
			reg_wdata <= ~d;
		end
	endtask
endmodule

/* File: test/led_mode_protection_control_tb.sv */
`timescale 1ns/1ps
module led_mode_protection_control_tb;
	reg        clk_sys = 1'b0;
	reg        rst = 1'b1;
	reg        trg = 1'b0;
	reg        fdone = 1'b0;
	reg        hot = 1'b0;
	reg [31:0] r;
	wire       reg_wr, pump_run, precharge_on, bias, torch_active, fault;
	wire [7:0] reg_addr, reg_wdata, reg_rdata;
	wire [1:0] gate_drive;
	wire [1:0] tmir;
	wire       imir;
	wire       lamp;
	wire       ftmo;
	reg        lit = 1'b0;
	integer    err_count = 0;
	integer    total_checks = 0;
	integer    seed = 32'h5ad6;
	integer    i;
	integer    mdl [0:63];
	always #5 clk_sys = ~clk_sys;
	host_model host_model_i (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
	led_mode_protection_control #(.LAMP_TIMEOUT_CYCLES(50)) led_mode_protection_control_i (.clk_sys(clk_sys),
		.rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.flash_trigger_pin(trg), .flash_done(fdone), .light_above_threshold(lit), .thermistor_below_ref(hot),
		.pump_run(pump_run), .precharge_on(precharge_on), .sensor_bias_output(bias), .gate_drive(gate_drive),
		.torch_mirror_on(tmir), .indicator_mirror_on(imir), .torch_active(torch_active),
		.lamp_timeout_active(lamp), .flash_timeout_active(ftmo), .thermal_fault(fault));
	// compare and count
	task chk(input [7:0] seen, input [7:0] exp);
		begin
			total_checks = total_checks + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("BAD %0t %h %h", $time, seen, exp);
			end
		end
	endtask
	task wrap_up;
		begin
			if (err_count == 0 && total_checks > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	// write, update model, let outputs settle
	task put(input [7:0] a, input [7:0] v);
		begin
			host_model_i.wr(a, v);
			mdl[a[5:0]] = v;
			repeat (3) @(posedge clk_sys);
			#1;
		end
	endtask
	// on a rising edge
	task drv(input h, input t, input f);
		begin
			@(posedge clk_sys);
			hot <= h;
			trg <= t;
			fdone <= f;
		end
	endtask
	initial begin
		mdl[1] = 0;
		mdl[2] = 0;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		for (i = 0; i < 24; i = i + 1) begin
			r = $random(seed);
			put(8'h02 - i[0], r[7:0] & 8'hef);
			chk(reg_rdata & (i[0] ? 8'h6b : 8'h67), mdl[2 - i[0]] & (i[0] ? 8'h6b : 8'h67));
			chk({7'h00, precharge_on}, {7'h00, mdl[2][1]});
			chk({7'h00, pump_run}, {7'h00, mdl[2][2]});
			chk({7'h00, bias}, {7'h00, mdl[2][2] | mdl[1][4]});
			chk({7'h00, torch_active & mdl[2][5]}, 8'h00);
		end
		put(8'h30, 8'h5a);
		chk(reg_rdata, 8'h00);
		put(8'h02, 8'h04);
		put(8'h01, 8'h40);
		drv(1'b1, 1'b0, 1'b0);
		repeat (3) @(posedge clk_sys);
		drv(1'b0, 1'b0, 1'b0);
		put(8'h09, 8'h80);
		chk({fault, pump_run}, 8'h02);
		put(8'h09, 8'h00);
		chk({fault, pump_run}, 8'h01);
		put(8'h01, 8'h03);
		put(8'h02, 8'h66);
		drv(1'b0, 1'b1, 1'b0);
		repeat (3) @(posedge clk_sys);
		#1;
		chk({gate_drive, pump_run}, 8'h07);
		drv(1'b0, 1'b0, 1'b1);
		drv(1'b0, 1'b0, 1'b0);
		repeat (3) @(posedge clk_sys);
		#1;
		chk({6'h00, gate_drive}, 8'h00);
		// torch, picture light timeout, indicator suspend and restore
		put(8'h02, 8'h04);
		chk({6'h00, tmir}, 8'h03);
		chk({7'h00, lamp}, 8'h00);
		put(8'h05, 8'h40);
		chk({7'h00, lamp}, 8'h01);
		chk({6'h00, tmir}, 8'h03);
		repeat (60) @(posedge clk_sys);
		#1;
		chk({6'h00, tmir}, 8'h00);
		put(8'h02, 8'h05);
		chk({7'h00, imir}, 8'h01);
		chk({6'h00, tmir}, 8'h00);
		chk({7'h00, ftmo}, 8'h00);
		put(8'h02, 8'h04);
		chk({7'h00, imir}, 8'h00);
		chk({6'h00, tmir}, 8'h03);
		put(8'h05, 8'h10);
		// light feedback truncation and rearm
		put(8'h01, 8'h23);
		put(8'h02, 8'h66);
		drv(1'b0, 1'b1, 1'b0);
		repeat (2) @(posedge clk_sys);
		#1;
		chk({6'h00, gate_drive}, 8'h03);
		chk({7'h00, ftmo}, 8'h01);
		drv(1'b0, 1'b0, 1'b0);
		lit <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		chk({6'h00, gate_drive}, 8'h00);
		put(8'h30, 8'h00);
		chk(reg_rdata, 8'h02);
		drv(1'b0, 1'b1, 1'b0);
		lit <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		chk({6'h00, gate_drive}, 8'h03);
		drv(1'b0, 1'b0, 1'b1);
		drv(1'b0, 1'b0, 1'b0);
		repeat (3) @(posedge clk_sys);
		#1;
		chk({6'h00, gate_drive}, 8'h00);
		wrap_up;
	end
endmodule
